// ==== hw/wdpc_pkg.sv ====
// Package for the protected watchdog control block.
// Assumes an APB slave with 32-bit data; all registers are one aligned word.
package wdpc_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [15:0] WDPC_CTRL_OFS = 16'hffb1;
   localparam logic [17:0] WDPC_CTRL_ADDR = {WDPC_CTRL_OFS, 2'b00};
   localparam logic [17:0] WDPC_CNT_ADDR = 18'h00000;
   localparam logic [17:0] WDPC_IRQ_STAT_ADDR = 18'h00004;
   localparam logic [17:0] WDPC_IRQ_MASK_ADDR = 18'h00008;

   // ----------------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------------
   localparam int WDPC_CNT_WEN_GUARD_BIT = 7;
   localparam int WDPC_CNT_WEN_BIT = 6;
   localparam int WDPC_CTL_WEN_GUARD_BIT = 5;
   localparam int WDPC_CTL_WEN_BIT = 4;
   localparam int WDPC_RUN_GUARD_BIT = 3;
   localparam int WDPC_RUN_BIT = 2;
   localparam int WDPC_OVF_GUARD_BIT = 1;
   localparam int WDPC_OVF_BIT = 0;
   localparam logic [7:0] WDPC_GUARD_MASK = 8'haa;
   localparam logic [7:0] WDPC_CTRL_RESET = 8'haa;
   localparam logic [7:0] WDPC_CNT_RESET = 8'h00;
   localparam logic [7:0] WDPC_CNT_MAX = 8'hff;

   // ----------------------------------------------------------------------
   // Interrupt status bits
   // ----------------------------------------------------------------------
   localparam int WDPC_IRQ_OVF_BIT = 0;
   localparam logic [1:0] WDPC_IRQ_RESET = 2'h0;

   typedef struct packed {
      logic write;
      logic [31:0] wdata;
   } wdpc_wr_s;

endpackage

// ==== hw/wdpc_top.sv ====
// Watchdog control/status register with per-bit write guards and counter.
// Assumes APB master on clk; external_reset_pin_n is an asynchronous pin input.
//
// Functional notes
// - Counter write enable changes only with guard bit 7 written 0; bit 7 reads 1.
// - Counter writes accepted only while counter write enable is 1.
// - Control write enable changes only with guard bit 5 written 0; bit 5 reads 1.
// - Run bit and overflow flag writes take effect only while control write enable is 1.
// - Run bit set by write of guard 3 zero and bit 2 one when enabled.
// - Run bit cleared by write of guard 3 zero and bit 2 zero when enabled.
// - Counter increments while run bit is 1, holds while 0.
// - Counter overflow sets overflow flag and pulses internal reset.
// - External reset pin clears the flag; watchdog reset leaves it set.
// - Flag cleared by write of guard 1 zero and bit 0 zero when enabled.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wdpc_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic external_reset_pin_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic wdt_reset,
   output logic irq
);
   import wdpc_pkg::*;

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   wdpc_wr_s wr;
   wire access = psel && penable;
   wire sel_ctrl = paddr[17:0] == WDPC_CTRL_ADDR;
   wire sel_cnt = paddr[17:0] == WDPC_CNT_ADDR;
   wire sel_stat = paddr[17:0] == WDPC_IRQ_STAT_ADDR;
   wire sel_mask = paddr[17:0] == WDPC_IRQ_MASK_ADDR;
   wire hit = (sel_ctrl || sel_cnt || sel_stat || sel_mask) && paddr[31:18] == 14'h0000;
   assign wr = '{write: access && pwrite && hit, wdata: pwdata};
   assign pready = 1'b1;
   assign pslverr = access && !hit;

   // ----------------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------------
   logic ext_meta_reg;
   logic ext_sync_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         // Reset to the pin's idle level, so that no pin reset is seen just after release.
         ext_meta_reg <= 1'b1;
         ext_sync_reg <= 1'b1;
      end else begin
         ext_meta_reg <= external_reset_pin_n;
         ext_sync_reg <= ext_meta_reg;
      end
   end
   wire ext_reset = !ext_sync_reg;

   // ----------------------------------------------------------------------
   // Protected control bits
   // ----------------------------------------------------------------------
   logic counter_write_enable_reg;
   logic control_write_enable_reg;
   logic watchdog_run_reg;
   logic overflow_reset_flag_reg;
   logic [7:0] watchdog_counter_reg;
   logic wdt_reset_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_mask_reg;
   logic [31:0] prdata_reg;

   wire ctrl_wr = wr.write && sel_ctrl;
   wire [7:0] wb = wr.wdata[7:0];
   // A guard written 1 blocks its companion bit.
   wire cnt_wen_upd = ctrl_wr && !wb[WDPC_CNT_WEN_GUARD_BIT];
   wire ctl_wen_upd = ctrl_wr && !wb[WDPC_CTL_WEN_GUARD_BIT];
   wire run_upd = ctrl_wr && control_write_enable_reg
      && !wb[WDPC_RUN_GUARD_BIT];
   wire ovf_clr = ctrl_wr && control_write_enable_reg && !wb[WDPC_OVF_GUARD_BIT]
      && !wb[WDPC_OVF_BIT];
   wire cnt_wr = wr.write && sel_cnt && counter_write_enable_reg;
   wire overflow = watchdog_run_reg && watchdog_counter_reg == WDPC_CNT_MAX && !cnt_wr;

   wire counter_write_enable_next = cnt_wen_upd ? wb[WDPC_CNT_WEN_BIT]
      : counter_write_enable_reg;
   wire control_write_enable_next = ctl_wen_upd ? wb[WDPC_CTL_WEN_BIT]
      : control_write_enable_reg;
   wire watchdog_run_next = run_upd ? wb[WDPC_RUN_BIT] : watchdog_run_reg;
   // Overflow set wins over a same-cycle software clear.
   wire overflow_reset_flag_next = overflow ? 1'b1
      : (ovf_clr ? 1'b0 : overflow_reset_flag_reg);

   // The external pin clears these control bits including the flag, but not the interrupt registers; the watchdog reset does not.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         counter_write_enable_reg <= 1'b0;
         control_write_enable_reg <= 1'b0;
         watchdog_run_reg <= 1'b0;
         overflow_reset_flag_reg <= 1'b0;
      end else if (ext_reset) begin
         counter_write_enable_reg <= 1'b0;
         control_write_enable_reg <= 1'b0;
         watchdog_run_reg <= 1'b0;
         overflow_reset_flag_reg <= 1'b0;
      end else begin
         counter_write_enable_reg <= counter_write_enable_next;
         control_write_enable_reg <= control_write_enable_next;
         watchdog_run_reg <= watchdog_run_next;
         overflow_reset_flag_reg <= overflow_reset_flag_next;
      end
   end

   // ----------------------------------------------------------------------
   // Counter and internal reset
   // ----------------------------------------------------------------------
   wire [7:0] watchdog_counter_next = cnt_wr ? wb
      : (watchdog_run_reg ? watchdog_counter_reg + 8'h01 : watchdog_counter_reg);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         watchdog_counter_reg <= WDPC_CNT_RESET;
         wdt_reset_reg <= 1'b0;
      end else if (ext_reset) begin
         watchdog_counter_reg <= WDPC_CNT_RESET;
         wdt_reset_reg <= 1'b0;
      end else begin
         watchdog_counter_reg <= watchdog_counter_next;
         wdt_reset_reg <= overflow;
      end
   end
   assign wdt_reset = wdt_reset_reg;

   // ----------------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------------
   wire [1:0] irq_event = {1'b0, overflow};
   wire [1:0] irq_w1c = (wr.write && sel_stat) ? wr.wdata[1:0] : 2'h0;
   wire [1:0] irq_stat_next = irq_event | (irq_stat_reg & ~irq_w1c);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_reg <= WDPC_IRQ_RESET;
         irq_mask_reg <= WDPC_IRQ_RESET;
      end else begin
         irq_stat_reg <= irq_stat_next;
         if (wr.write && sel_mask) begin
            irq_mask_reg <= wr.wdata[1:0];
         end
      end
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   wire [7:0] ctrl_rd = WDPC_GUARD_MASK
      | {1'b0, counter_write_enable_reg, 1'b0, control_write_enable_reg,
         1'b0, watchdog_run_reg, 1'b0, overflow_reset_flag_reg};
   wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_rd}
      : sel_cnt ? {24'h000000, watchdog_counter_reg}
      : sel_stat ? {30'h00000000, irq_stat_reg}
      : sel_mask ? {30'h00000000, irq_mask_reg} : 32'h00000000;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_reg <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata_reg <= rd_mux;
      end
   end
   assign prdata = prdata_reg;
endmodule
`default_nettype wire

// ==== tb/wdpc_top_sva.sv ====
// Port checker for the protected watchdog control block.
// Assumes it is bound onto wdpc_top and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module wdpc_top_sva (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wdt_reset,
   input wire logic irq
);
   import wdpc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire logic acc = psel && penable;
   wire logic hit = paddr inside {32'(WDPC_CTRL_ADDR), 32'(WDPC_CNT_ADDR),
      32'(WDPC_IRQ_STAT_ADDR), 32'(WDPC_IRQ_MASK_ADDR)};
   property p_ready; psel |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_err_phase; pslverr |-> acc; endproperty
   a_err_phase: assert property (p_err_phase) else $error("error outside access");
   property p_err_miss; acc && !hit |-> pslverr; endproperty
   a_err_miss: assert property (p_err_miss) else $error("unmapped not refused");
   property p_err_hit; acc && hit |-> !pslverr; endproperty
   a_err_hit: assert property (p_err_hit) else $error("mapped refused");
   property p_pulse; wdt_reset |=> !wdt_reset; endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse too long");
   property p_irq; $rose(irq) |-> wdt_reset || $past(wdt_reset) || $past(acc && pwrite);
   endproperty
   a_irq: assert property (p_irq) else $error("irq without cause");
   property p_guard; acc && !pwrite && paddr == 32'(WDPC_CTRL_ADDR)
      |-> (prdata & 32'h000000aa) == 32'h000000aa && prdata[31:8] == 24'h0; endproperty
   a_guard: assert property (p_guard) else $error("guard bits not read as one");
   property p_miss_rd; acc && !pwrite && !hit |-> prdata == 32'h0; endproperty
   a_miss_rd: assert property (p_miss_rd) else $error("unmapped read not zero");
   c_ovf: cover property (wdt_reset);
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
endmodule
bind wdpc_top wdpc_top_sva u_sva (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .wdt_reset, .irq);
`default_nettype wire

// ==== tb/test_watchdog_protected_control.sv ====
// Self-checking bench for the protected watchdog control block.
// Assumes wdpc_pkg, wdpc_top and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_protected_control;
   import wdpc_pkg::*;
   typedef struct packed {logic [31:0] d; logic [31:0] m;} wdpc_exp_s;
   logic clk = 0, arst_n = 0, external_reset_pin_n = 1, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, r;
   logic pready, pslverr, wdt_reset, irq;
   int err_count = 0, compares = 0;
   wdpc_exp_s q[$];
   wdpc_exp_s e;
   localparam logic [31:0] CT = 32'(WDPC_CTRL_ADDR), CN = 32'(WDPC_CNT_ADDR);
   localparam logic [31:0] ST = 32'(WDPC_IRQ_STAT_ADDR), MK = 32'(WDPC_IRQ_MASK_ADDR);
   wdpc_top uut (.clk, .arst_n, .external_reset_pin_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .wdt_reset, .irq);
   always #25 clk = ~clk;
   task conclude;
      if (err_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Reads leave their expectation in the queue; the monitor below judges them.
   task apb(input logic w, input logic [31:0] a, d, input logic [31:0] m = 32'hffffffff);
      @(posedge clk);
      if (!w) q.push_back('{d, m});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task flag(input logic exp);
      @(negedge clk);
      cmp({31'h0, irq}, {31'h0, exp});
   endtask
   task ovf(input logic [7:0] start);
      int n;
      apb(1'b1, CT, 32'h50);
      apb(1'b1, CN, {24'h0, start});
      apb(1'b1, CT, 32'h54);
      apb(1'b1, CT, 32'h8a);
      n = 0;
      while (wdt_reset !== 1'b1 && n < 600) begin
         @(negedge clk);
         n++;
      end
      // Counting runs from the access edge of the 0x54 write, one step a clock.
      cmp(32'(n), 32'h000000fe - 32'(start));
   endtask
   always @(posedge clk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         e = q.pop_front();
         cmp(prdata & e.m, e.d & e.m);
      end
   end
   initial begin
      #150000;
      err_count++;
      conclude();
   end
   initial begin
      r = $urandom(51);
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      apb(1'b0, CT, 32'haa);
      apb(1'b1, CN, $urandom & 32'hff);
      apb(1'b0, CN, 32'h0);
      apb(1'b1, CT, 32'hc0);
      apb(1'b0, CT, 32'haa);
      apb(1'b1, CT, 32'h44);
      apb(1'b0, CT, 32'hea);
      apb(1'b1, CT, 32'h50);
      apb(1'b1, CT, 32'h54);
      apb(1'b0, CT, 32'hfe);
      apb(1'b1, CT, 32'h50);
      apb(1'b0, CT, 32'hfa);
      r = $urandom & 32'hff;
      apb(1'b1, CN, r);
      apb(1'b0, CN, r);
      ovf(8'($urandom_range(192, 240)));
      apb(1'b0, CT, 32'h1, 32'h1);
      apb(1'b0, ST, 32'h1);
      apb(1'b0, MK, 32'h0);
      flag(1'b0);
      apb(1'b1, MK, 32'h1);
      flag(1'b1);
      apb(1'b1, CT, 32'h88);
      apb(1'b0, CT, 32'h1, 32'h1);
      apb(1'b1, CT, 32'h9a);
      apb(1'b1, CT, 32'h9a);
      apb(1'b0, CT, 32'h1, 32'h1);
      apb(1'b1, CT, 32'h98);
      apb(1'b0, CT, 32'h0, 32'h1);
      apb(1'b1, ST, 32'h1);
      flag(1'b0);
      ovf(8'($urandom_range(192, 240)));
      flag(1'b1);
      @(posedge clk);
      external_reset_pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      external_reset_pin_n <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, CT, 32'haa);
      apb(1'b1, 32'h100, $urandom);
      apb(1'b0, 32'h100, 32'h0);
      conclude();
   end
endmodule
`default_nettype wire
